// file: logic/rcsp_regs.svh
// Purpose: constants for the recorder command/status port
// Assumes: 100 MHz reference clock
// Notes: times kept in their own unit, cycle counts derived
`ifndef RCSP_REGS_SVH
`define RCSP_REGS_SVH
`define RCSP_CLK_MHZ 100
`define RCSP_CMD_ERASE 4'hd
`define RCSP_CMD_LEVEL 4'he
`define RCSP_CMD_IDLE 4'hf
`define RCSP_ST_BUSY 0
`define RCSP_ST_RPM 1
`define RCSP_ST_VWP 2
`define RCSP_ST_NAR 3
`define RCSP_ST_RESET 4'h8
`define RCSP_CMD_BUSY_US 16
`define RCSP_CMD_BUSY_CYC (`RCSP_CMD_BUSY_US * `RCSP_CLK_MHZ)
`define RCSP_RESET_BUSY_US 1000
`define RCSP_RESET_BUSY_CYC (`RCSP_RESET_BUSY_US * `RCSP_CLK_MHZ)
`define RCSP_ERASE_BUSY_US 550000
`define RCSP_ERASE_BUSY_CYC (`RCSP_ERASE_BUSY_US * `RCSP_CLK_MHZ)
`define RCSP_STROBE_CYC 4
`define RCSP_REG_CTRL 32'h0000_0000
`define RCSP_REG_STAT 32'h0000_0004
`define RCSP_REG_IRQ 32'h0000_0008
`define RCSP_REG_MASK 32'h0000_000c
`endif

// file: logic/rcsp_pkg.sv
// Purpose: types for the recorder command/status port
// Assumes: nothing
// Notes: record/playback modes and level encodings
package rcsp_pkg;
  typedef enum logic [2:0] {
    RCSP_MODE_FLEX, RCSP_MODE_ROM_ADDR, RCSP_MODE_DIRECT,
    RCSP_MODE_DIRECT_ROM, RCSP_MODE_EXT
  } rcsp_mode_t;
  typedef enum logic [1:0] {
    RCSP_ATT_0DB, RCSP_ATT_M6DB, RCSP_ATT_M12DB
  } rcsp_atten_t;
  typedef enum logic [1:0] {
    RCSP_RAMP_OFF, RCSP_RAMP_UP, RCSP_RAMP_DOWN
  } rcsp_ramp_t;
endpackage

// file: logic/rcsp_if.sv
// Purpose: nibble port between recorder device and host
// Assumes: one clock domain on the host side
// Notes: data bus resolved from the two enables
`timescale 1ns/1ps
interface rcsp_if;
  logic [3:0] host_d;
  logic host_d_oe;
  logic [3:0] dev_d;
  logic dev_d_oe;
  logic wr_n;
  logic rd_n;
  logic ce_n;
  logic [3:0] stat_pins;
  logic [3:0] d_bus;
  assign d_bus = dev_d_oe ? dev_d : (host_d_oe ? host_d : 4'hf);
  modport dev (input host_d, host_d_oe, wr_n, rd_n, ce_n, d_bus,
    output dev_d, dev_d_oe, stat_pins);
  modport host (input dev_d, dev_d_oe, stat_pins, d_bus,
    output host_d, host_d_oe, wr_n, rd_n, ce_n);
endinterface

// file: logic/rcsp_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: destination clock ref_clk_i
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module rcsp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic ref_clk_i, // clock
  input wire logic resetn_i, // async reset, low
  input wire logic [WIDTH-1:0] d_i, // asynchronous input
  output logic [WIDTH-1:0] q_o // synchronised output
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
    end
  end
  assign q_o = s2_reg;
endmodule

// file: logic/rcsp_device.sv
// Purpose: recorder command decoder and 4-bit status port
// Assumes: pins asynchronous; reset pin high-active resets the device
// Notes: playback datapath is outside; its status comes in as inputs
// How it works
// R1: level cmd Eh, second nibble sets attenuation/ramp
// R2: voice trigger only in flex/direct modes
// R3: erase all only in flex/direct modes
// R4: four-bit status: accept, wait, active, busy
// R5: read strobe with enable drives status out
// R6: status bits also on dedicated pins
// R7: busy during reset sequence or command processing
// R8: host never writes while busy is high
// R9: host waits busy time or busy pin
// R10: reset pulse raises busy until sequence ends
// R11: active high while recording or playing back
// R12: host sends only permitted commands while active
// R13: reset clears record/play active
// R14: wait/pause while voice-waiting or paused
// R15: accept high permits phrase select; reset sets
// R16: host places nibble, then pulses write low
// R17: erase and idle commands decoded
// R18: read value frozen for whole strobe
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "rcsp_regs.svh"
module rcsp_device #(
  parameter int RESET_BUSY_CYC = `RCSP_RESET_BUSY_CYC,
  parameter int ERASE_BUSY_CYC = `RCSP_ERASE_BUSY_CYC,
  parameter int CMD_BUSY_CYC = `RCSP_CMD_BUSY_CYC
) (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic resetn_i, // async reset, low
  input wire logic dev_reset_i, // reset pin, high pulse
  rcsp_if.dev port, // nibble port
  input wire rcsp_pkg::rcsp_mode_t mode_i, // record/playback mode
  input wire logic voice_trig_req_i, // voice trigger configured
  input wire logic rec_play_i, // datapath recording/playing
  input wire logic voice_wait_i, // waiting for voice
  input wire logic paused_i, // paused by pause command
  input wire logic phrase_ok_i, // phrase designation allowed
  output logic [3:0] cmd_o, // last first nibble
  output logic cmd_valid_o, // pulse: command taken
  output rcsp_pkg::rcsp_atten_t atten_o, // output attenuation
  output rcsp_pkg::rcsp_ramp_t ramp_o, // dc ramp select
  output logic ramp_go_o, // pulse: start dc ramp
  output logic erase_all_o, // pulse: erase all memory
  output logic voice_trig_en_o // voice trigger in effect
);
  import rcsp_pkg::*;
  typedef enum {RCSP_S_RESET, RCSP_S_IDLE, RCSP_S_LEVEL2,
    RCSP_S_BUSY} rcsp_state_t;
  localparam int CW = 32;

  logic [3:0] d_s;
  logic wr_n_s, rd_n_s, ce_n_s, rst_s;
  rcsp_sync #(.WIDTH(8), .INIT(8'hfe)) u_sync (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .d_i({port.d_bus, port.wr_n, port.rd_n, port.ce_n, dev_reset_i}),
    .q_o({d_s, wr_n_s, rd_n_s, ce_n_s, rst_s})
  );

  rcsp_state_t state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic wr_d_reg;
  logic [3:0] cmd_reg, cmd_next;
  logic cmd_valid_reg, cmd_valid_next;
  rcsp_atten_t att_reg, att_next;
  rcsp_ramp_t ramp_reg, ramp_next;
  logic ramp_go_reg, ramp_go_next;
  logic erase_reg, erase_next;
  logic [3:0] stat_reg, stat_next;
  logic [3:0] rd_data_reg, rd_data_next;
  logic rd_d_reg;
  logic wr_edge, rd_fall, rd_act, ok_mode;

  // strobe edges from synchronised pins; disabled port ignores both
  assign wr_edge = !wr_n_s && wr_d_reg && !ce_n_s;
  assign rd_act = !rd_n_s && !ce_n_s;
  assign rd_fall = rd_act && rd_d_reg;
  assign ok_mode = (mode_i == RCSP_MODE_FLEX) ||
                   (mode_i == RCSP_MODE_DIRECT);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cmd_next = cmd_reg;
    cmd_valid_next = 1'b0;
    att_next = att_reg;
    ramp_next = ramp_reg;
    ramp_go_next = 1'b0;
    erase_next = 1'b0;
    if (rst_s) begin
      state_next = RCSP_S_RESET; // see R10
      cnt_next = CW'(RESET_BUSY_CYC);
    end else begin
      case (state_reg)
        RCSP_S_RESET: begin
          if (cnt_reg <= 1) state_next = RCSP_S_IDLE;
          else cnt_next = cnt_reg - 1'b1;
        end
        RCSP_S_IDLE: begin
          if (wr_edge) begin
            cmd_next = d_s;
            cmd_valid_next = 1'b1;
            state_next = RCSP_S_BUSY;
            cnt_next = CW'(CMD_BUSY_CYC);
            case (d_s)
              `RCSP_CMD_LEVEL: state_next = RCSP_S_LEVEL2; // see R1
              `RCSP_CMD_ERASE: begin
                // see R3 R17
                if (ok_mode) begin
                  erase_next = 1'b1;
                  cnt_next = CW'(ERASE_BUSY_CYC);
                end
              end
              // idle command only costs the short busy, see R17
              default: ;
            endcase
          end
        end
        RCSP_S_LEVEL2: begin
          // first nibble keeps busy too; strobes in that time are lost
          if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1; // see R7
          end else if (wr_edge) begin
            // 00/01 both give 0 dB, ramp 0x is off, see R1
            case (d_s[3:2])
              2'b10: att_next = RCSP_ATT_M6DB;
              2'b11: att_next = RCSP_ATT_M12DB;
              default: att_next = RCSP_ATT_0DB;
            endcase
            case (d_s[1:0])
              2'b10: ramp_next = RCSP_RAMP_UP;
              2'b11: ramp_next = RCSP_RAMP_DOWN;
              default: ramp_next = RCSP_RAMP_OFF;
            endcase
            ramp_go_next = d_s[1];
            state_next = RCSP_S_BUSY;
            cnt_next = CW'(CMD_BUSY_CYC);
          end
        end
        RCSP_S_BUSY: begin
          if (cnt_reg <= 1) state_next = RCSP_S_IDLE;
          else cnt_next = cnt_reg - 1'b1;
        end
        default: state_next = RCSP_S_IDLE;
      endcase
    end
  end

  always_comb begin
    stat_next[`RCSP_ST_BUSY] = (state_next == RCSP_S_RESET) ||
                               (state_next == RCSP_S_BUSY) ||
                               (state_next == RCSP_S_LEVEL2 &&
                                cnt_next != '0); // see R7
    if (state_next == RCSP_S_RESET) begin
      stat_next[`RCSP_ST_RPM] = 1'b0; // see R13
      stat_next[`RCSP_ST_VWP] = 1'b0; // see R14
      stat_next[`RCSP_ST_NAR] = 1'b1; // see R15
    end else begin
      stat_next[`RCSP_ST_RPM] = rec_play_i; // see R11
      stat_next[`RCSP_ST_VWP] = voice_wait_i || paused_i; // see R14
      stat_next[`RCSP_ST_NAR] = phrase_ok_i; // see R15
    end
    // capture on the falling strobe only, see R18
    rd_data_next = rd_fall ? stat_reg : rd_data_reg;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= RCSP_S_RESET;
      cnt_reg <= CW'(RESET_BUSY_CYC);
      wr_d_reg <= 1'b1;
      rd_d_reg <= 1'b1;
      cmd_reg <= 4'h0;
      cmd_valid_reg <= 1'b0;
      att_reg <= RCSP_ATT_0DB;
      ramp_reg <= RCSP_RAMP_OFF;
      ramp_go_reg <= 1'b0;
      erase_reg <= 1'b0;
      stat_reg <= `RCSP_ST_RESET; // see R4
      rd_data_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      wr_d_reg <= wr_n_s;
      rd_d_reg <= !rd_act;
      cmd_reg <= cmd_next;
      cmd_valid_reg <= cmd_valid_next;
      att_reg <= att_next;
      ramp_reg <= ramp_next;
      ramp_go_reg <= ramp_go_next;
      erase_reg <= erase_next;
      stat_reg <= stat_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign port.dev_d = rd_data_reg; // see R5
  // enable lags capture by design: data reg is loaded on rd_fall
  assign port.dev_d_oe = rd_act && !rd_d_reg; // see R5
  assign port.stat_pins = stat_reg; // see R6
  assign cmd_o = cmd_reg;
  assign cmd_valid_o = cmd_valid_reg;
  assign atten_o = att_reg;
  assign ramp_o = ramp_reg;
  assign ramp_go_o = ramp_go_reg;
  assign erase_all_o = erase_reg;
  assign voice_trig_en_o = voice_trig_req_i && ok_mode; // see R2
endmodule

// file: logic/rcsp_host.sv
// Purpose: host end: APB registers drive nibble writes and reads
// Assumes: device status pins asynchronous to ref_clk_i
// Notes: a write or read request waits while the busy pin is high
`timescale 1ns/1ps
`include "rcsp_regs.svh"
module rcsp_host (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic resetn_i, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [31:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic irq_o, // interrupt, level
  rcsp_if.host port // nibble port
);
  import rcsp_pkg::*;
  typedef enum {RCSP_H_IDLE, RCSP_H_WAIT, RCSP_H_SETUP, RCSP_H_STROBE,
    RCSP_H_HOLD} rcsp_hstate_t;

  logic [3:0] stat_s, d_s;
  rcsp_sync #(.WIDTH(8), .INIT(8'h8f)) u_sync (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .d_i({port.stat_pins, port.d_bus}),
    .q_o({stat_s, d_s})
  );

  rcsp_hstate_t st_reg, st_next;
  logic [2:0] cnt_reg, cnt_next;
  logic op_rd_reg, op_rd_next;
  logic [3:0] nib_reg, nib_next;
  logic [3:0] rdat_reg, rdat_next;
  logic [1:0] irq_reg, irq_next;
  logic [1:0] mask_reg, mask_next;
  logic busy_d_reg;
  logic acc, wr_ctrl, rd_irq, done;

  assign acc = psel && penable;
  assign wr_ctrl = acc && pwrite && paddr == `RCSP_REG_CTRL &&
                   st_reg == RCSP_H_IDLE;
  assign rd_irq = acc && !pwrite && paddr == `RCSP_REG_IRQ;
  assign done = st_reg == RCSP_H_HOLD && cnt_reg == 3'd0;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    op_rd_next = op_rd_reg;
    nib_next = nib_reg;
    rdat_next = rdat_reg;
    case (st_reg)
      RCSP_H_IDLE: begin
        if (wr_ctrl) begin
          nib_next = pwdata[3:0];
          op_rd_next = pwdata[8];
          st_next = RCSP_H_WAIT;
        end
      end
      RCSP_H_WAIT: begin
        // busy pin checked, not the read strobe, see R8 R9
        if (!stat_s[`RCSP_ST_BUSY]) begin
          st_next = RCSP_H_SETUP;
          cnt_next = 3'(`RCSP_STROBE_CYC);
        end
      end
      RCSP_H_SETUP: begin
        // data settles before the write strobe falls, see R16
        st_next = RCSP_H_STROBE;
        cnt_next = 3'(`RCSP_STROBE_CYC);
      end
      RCSP_H_STROBE: begin
        if (cnt_reg == 3'd0) begin
          st_next = RCSP_H_HOLD;
          cnt_next = 3'(`RCSP_STROBE_CYC);
        end else begin
          cnt_next = cnt_reg - 3'd1;
        end
      end
      RCSP_H_HOLD: begin
        // hold out the device's synchroniser plus busy rise
        // read nibble crosses both synchronisers; sample mid hold
        if (op_rd_reg && cnt_reg == 3'd2) rdat_next = d_s;
        if (cnt_reg == 3'd0) st_next = RCSP_H_IDLE;
        else cnt_next = cnt_reg - 3'd1;
      end
      default: st_next = RCSP_H_IDLE;
    endcase
    // irq: bit0 transfer done, bit1 device busy fell; set beats clear
    irq_next = rd_irq ? 2'b00 : irq_reg;
    irq_next[0] = irq_next[0] || done;
    irq_next[1] = irq_next[1] || (busy_d_reg && !stat_s[`RCSP_ST_BUSY]);
    mask_next = mask_reg;
    if (acc && pwrite && paddr == `RCSP_REG_MASK) mask_next = pwdata[1:0];
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= RCSP_H_IDLE;
      cnt_reg <= 3'd0;
      op_rd_reg <= 1'b0;
      nib_reg <= 4'h0;
      rdat_reg <= 4'h0;
      irq_reg <= 2'b00;
      mask_reg <= 2'b00;
      busy_d_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      op_rd_reg <= op_rd_next;
      nib_reg <= nib_next;
      rdat_reg <= rdat_next;
      irq_reg <= irq_next;
      mask_reg <= mask_next;
      busy_d_reg <= stat_s[`RCSP_ST_BUSY];
    end
  end

  always_comb begin
    prdata = 32'h0;
    pslverr = 1'b0;
    case (paddr)
      `RCSP_REG_CTRL: prdata = {23'h0, op_rd_reg, 4'h0, nib_reg};
      `RCSP_REG_STAT: prdata = {23'h0, st_reg != RCSP_H_IDLE, 4'h0,
                                stat_s};
      `RCSP_REG_IRQ: prdata = {30'h0, irq_reg};
      `RCSP_REG_MASK: prdata = {30'h0, mask_reg};
      default: pslverr = psel && penable;
    endcase
    prdata[19:16] = (paddr == `RCSP_REG_STAT) ? rdat_reg : 4'h0;
  end

  assign pready = 1'b1;
  assign irq_o = |(irq_reg & mask_reg);
  assign port.host_d = nib_reg;
  assign port.host_d_oe = !op_rd_reg &&
    (st_reg == RCSP_H_SETUP || st_reg == RCSP_H_STROBE ||
     st_reg == RCSP_H_HOLD);
  assign port.ce_n = 1'b0;
  assign port.wr_n = !(st_reg == RCSP_H_STROBE && !op_rd_reg);
  assign port.rd_n = !(st_reg == RCSP_H_STROBE && op_rd_reg);
endmodule

// file: tb/rcsp_props.sv
// Purpose: wire-level checks on the nibble port between the two ends
// Assumes: one clock, async low reset
// Notes: device busy counts shortened by the bench
`timescale 1ns/1ps
module rcsp_props (
  input wire logic ref_clk_i, // clock
  input wire logic resetn_i, // async reset, low
  input wire logic [3:0] host_d, // host nibble
  input wire logic host_d_oe, // host drives
  input wire logic [3:0] dev_d, // device nibble
  input wire logic dev_d_oe, // device drives
  input wire logic wr_n, // write strobe
  input wire logic rd_n, // read strobe
  input wire logic ce_n, // port enable
  input wire logic [3:0] stat_pins, // status pins
  input wire logic [3:0] d_bus // resolved bus
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  sequence wr_strobe;
    (!wr_n) [*5] ##1 wr_n;
  endsequence
  sequence busy_hold;
    stat_pins[0] [*8];
  endsequence
  AST_WR_NOT_BUSY: assert property (
    $fell(wr_n) |-> !stat_pins[0]) else $error("write while busy");
  AST_WR_PULSE: assert property (
    $fell(wr_n) |-> wr_strobe) else $error("write strobe length");
  AST_WR_DATA: assert property (
    !wr_n |-> host_d_oe && $stable(host_d)) else $error("write data moved");
  AST_BUSY_RISE: assert property (
    $fell(wr_n) && !ce_n |-> ##[1:8] stat_pins[0])
    else $error("busy did not rise");
  AST_BUSY_MIN: assert property (
    $rose(stat_pins[0]) |-> busy_hold) else $error("busy too short");
  AST_BUSY_END: assert property (
    $rose(stat_pins[0]) |-> ##[8:200] !stat_pins[0])
    else $error("busy never ended");
  AST_RESET_STAT: assert property (
    $rose(resetn_i) |-> stat_pins[3:1] == 3'b100 ##[0:3] stat_pins[0])
    else $error("bad status after reset");
  AST_RD_DRIVE: assert property (
    $fell(rd_n) && !ce_n |-> ##[1:5] dev_d_oe) else $error("read not driven");
  AST_RD_STABLE: assert property (
    dev_d_oe && $past(dev_d_oe) |-> $stable(dev_d) && d_bus == dev_d)
    else $error("read data moved");
  AST_ONE_DRIVER: assert property (
    !(dev_d_oe && host_d_oe)) else $error("bus contention");
endmodule

// file: tb/recorder_command_status_port_tb_top.sv
// Purpose: drives the host end over APB against the device end
// Assumes: device busy counts shortened to 20, 50 and 10 cycles
// Notes: pulse outputs of the device are counted, not sampled
`timescale 1ns/1ps
`include "rcsp_regs.svh"
module recorder_command_status_port_tb_top;
  import rcsp_pkg::*;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic dev_reset_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, irq_o, er, hit;
  rcsp_mode_t mode_i = RCSP_MODE_FLEX;
  logic voice_trig_req_i = 1'b1, rec_play_i = 1'b0, voice_wait_i = 1'b0;
  logic paused_i = 1'b0, phrase_ok_i = 1'b1;
  logic [3:0] cmd_o;
  logic cmd_valid_o, ramp_go_o, erase_all_o, voice_trig_en_o;
  rcsp_atten_t atten_o;
  rcsp_ramp_t ramp_o;
  int n_mismatch = 0, check_count = 0, n_ramp = 0, n_erase = 0;
  int exp_ramp = 0, exp_erase = 0, n_cmd = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (ramp_go_o === 1'b1) n_ramp++;
    if (erase_all_o === 1'b1) n_erase++;
    if (cmd_valid_o === 1'b1) n_cmd++;
  end
  rcsp_if rcsp_if_i();
  rcsp_device #(.RESET_BUSY_CYC(20), .ERASE_BUSY_CYC(50), .CMD_BUSY_CYC(10))
    rcsp_device_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .dev_reset_i(dev_reset_i), .port(rcsp_if_i), .mode_i(mode_i),
    .voice_trig_req_i(voice_trig_req_i), .rec_play_i(rec_play_i),
    .voice_wait_i(voice_wait_i), .paused_i(paused_i),
    .phrase_ok_i(phrase_ok_i), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o),
    .atten_o(atten_o), .ramp_o(ramp_o), .ramp_go_o(ramp_go_o),
    .erase_all_o(erase_all_o), .voice_trig_en_o(voice_trig_en_o));
  rcsp_host rcsp_host_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_o(irq_o), .port(rcsp_if_i));
  rcsp_props rcsp_props_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .host_d(rcsp_if_i.host_d), .host_d_oe(rcsp_if_i.host_d_oe),
    .dev_d(rcsp_if_i.dev_d), .dev_d_oe(rcsp_if_i.dev_d_oe),
    .wr_n(rcsp_if_i.wr_n), .rd_n(rcsp_if_i.rd_n), .ce_n(rcsp_if_i.ce_n),
    .stat_pins(rcsp_if_i.stat_pins), .d_bus(rcsp_if_i.d_bus));
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [31:0] a, input logic [31:0] m,
      input logic [31:0] exp, input string s);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp, s);
  endtask
  // polls both transfer-running and the synced busy pin
  task wait_idle;
    int k;
    k = 0;
    do begin
      apb(1'b0, `RCSP_REG_STAT, 32'h0);
      k++;
    end while ((rd[8] !== 1'b0 || rd[0] !== 1'b0) && k < 300);
    if (k >= 300) chk(rd, 32'h0, "idle wait");
  endtask
  task stat_is(input logic [3:0] x);
    int k;
    k = 0;
    do begin
      apb(1'b0, `RCSP_REG_STAT, 32'h0);
      k++;
    end while (rd[3:0] !== x && k < 20);
    chk({28'h0, rd[3:0]}, {28'h0, x}, "status pins");
  endtask
  task send(input logic [3:0] n);
    apb(1'b1, `RCSP_REG_CTRL, {28'h0, n});
    wait_idle();
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    apb(1'b1, `RCSP_REG_MASK, 32'h2);
    wait_idle();
    @(negedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h1, "irq level");
    rdchk(`RCSP_REG_IRQ, 32'h3, 32'h2, "irq status");
    @(negedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h0, "irq cleared");
    rdchk(`RCSP_REG_MASK, 32'h3, 32'h2, "mask readback");
    apb(1'b0, 32'h0000_0010, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped");
    for (int i = 0; i < 16; i++) begin
      send(`RCSP_CMD_LEVEL);
      send(i[3:0]);
      exp_ramp += i[1];
      chk({30'h0, atten_o}, i[3] ? (i[2] ? 2 : 1) : 0, "atten");
      chk({30'h0, ramp_o}, i[1] ? (i[0] ? 2 : 1) : 0, "ramp");
      chk(n_ramp, exp_ramp, "ramp start");
      chk({28'h0, cmd_o}, 32'he, "level cmd");
    end
    chk(n_cmd, 32'd16, "cmd pulses");
    for (int m = 0; m < 5; m++) begin
      mode_i <= rcsp_mode_t'(m);
      send(`RCSP_CMD_ERASE);
      hit = (m == 0 || m == 2);
      exp_erase += hit;
      chk(n_erase, exp_erase, "erase");
      chk({31'h0, voice_trig_en_o}, {31'h0, hit}, "voice trig");
      chk({28'h0, cmd_o}, 32'hd, "erase cmd");
    end
    // masked event must stay off the interrupt line
    apb(1'b1, `RCSP_REG_MASK, 32'h0);
    apb(1'b0, `RCSP_REG_IRQ, 32'h0);
    send(`RCSP_CMD_IDLE);
    chk({28'h0, cmd_o}, 32'hf, "idle cmd");
    chk({30'h0, atten_o}, 32'h2, "idle keeps level");
    chk(n_erase, exp_erase, "idle no erase");
    chk(n_cmd, 32'd22, "idle cmd pulse");
    chk({31'h0, irq_o}, 32'h0, "masked irq");
    rdchk(`RCSP_REG_IRQ, 32'h3, 32'h3, "irq events");
    rec_play_i <= 1'b1;
    paused_i <= 1'b1;
    phrase_ok_i <= 1'b0;
    stat_is(4'b0110);
    send(`RCSP_CMD_LEVEL);
    send(4'h4);
    chk({30'h0, atten_o}, 32'h0, "level while active");
    chk({30'h0, ramp_o}, 32'h0, "ramp while active");
    chk(n_ramp, exp_ramp, "no ramp while active");
    chk(n_cmd, 32'd23, "cmd while active");
    apb(1'b1, `RCSP_REG_CTRL, 32'h100);
    wait_idle();
    rdchk(`RCSP_REG_STAT, 32'hf_0000, 32'h6_0000, "read nibble");
    rec_play_i <= 1'b0;
    paused_i <= 1'b0;
    voice_wait_i <= 1'b1;
    phrase_ok_i <= 1'b1;
    stat_is(4'b1100);
    voice_wait_i <= 1'b0;
    stat_is(4'b1000);
    rec_play_i <= 1'b1;
    paused_i <= 1'b1;
    phrase_ok_i <= 1'b0;
    dev_reset_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    dev_reset_i <= 1'b0;
    stat_is(4'b1001);
    rec_play_i <= 1'b0;
    paused_i <= 1'b0;
    phrase_ok_i <= 1'b1;
    wait_idle();
    stat_is(4'b1000);
    end_sim();
  end
  // tests need under two thousand cycles; allow over ten times that
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule
